// [verif/fcc_nbr_tile.sv]
// neighbour tile model: offers one carry to the slice
// assumes the bench sets direction and carry level
`timescale 1ns/10ps
module fcc_nbr_tile (
    // control
    input wire logic dir,
    input wire logic carry,
    // carry into the slice
    output logic from_below,
    output logic from_above
);
    // idle side shows the inverse, so a wrong pick is seen
    assign from_below = (dir == fcc_pkg::DIR_UP) ? carry : ~carry;
    assign from_above = (dir == fcc_pkg::DIR_DOWN) ? carry : ~carry;
endmodule

// [verif/fcc_slice_tb.sv]
// bench for the carry slice: exhaustive sweeps of both variants
// assumes fcc_pkg and fcc_nbr_tile are compiled first
`timescale 1ns/10ps
module fcc_slice_tb;
    logic core_clk = 1'b0, sys_rst = 1'b1;
    logic dir = 1'b0, sub = 1'b0, cend = 1'b0, cin = 1'b0;
    logic [1:0] sel = 2'h0, a = 2'h0, b = 2'h0, s0, s1;
    logic below, above, t0, b0, r0, t1, b1, r1;
    logic [2:0] r;
    int fails = 0, total_checks = 0;
    always #2 core_clk = ~core_clk;
    fcc_nbr_tile nbr (.dir(dir), .carry(cin), .from_below(below),
        .from_above(above));
    fcc_slice dut (.core_clk(core_clk), .sys_rst(sys_rst), .cfg_dir(dir),
        .cfg_sub(sub), .cfg_col_end(cend), .cfg_init_sel(sel), .op_a(a),
        .op_b(b), .lut_b_input_four(~cin), .bottom_carry_input(below),
        .downward_carry_input(above), .top_carry_exit(t0),
        .bottom_carry_exit(b0), .right_carry_exit(r0), .sum(s0));
    fcc_slice #(.VARIANT(fcc_pkg::VAR_UPONLY)) dut_up (.core_clk(core_clk),
        .sys_rst(sys_rst), .cfg_dir(dir), .cfg_sub(sub), .cfg_col_end(cend),
        .cfg_init_sel(sel), .op_a(a), .op_b(b), .lut_b_input_four(~cin),
        .bottom_carry_input(below), .downward_carry_input(above),
        .top_carry_exit(t1), .bottom_carry_exit(b1), .right_carry_exit(r1),
        .sum(s1));
    task automatic check(string what, logic [4:0] seen, logic [4:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // subtract adds the inverted operand, carry out means no borrow
    function automatic logic [2:0] add(logic c);
        return {1'b0, a} + {1'b0, sub ? ~b : b} + {2'h0, c};
    endfunction
    task automatic test_bidir();
        for (int i = 0; i < 256; i++)
        begin
            @(negedge core_clk);
            {sub, dir, cend, cin, a, b} = i[7:0];
            #1 r = add(cin);
            check("bidir", {t0, b0, r0, s0},
                {r[2] & ~cend & ~dir, r[2] & ~cend & dir, r[2] & cend, r[1:0]});
        end
        $display("bidir sweep done");
    endtask
    // up chain only; the idle down input carries the inverse
    task automatic test_uponly();
        // the bidir sweep ends with dir at down; this chain is fed from below
        @(negedge core_clk);
        dir = fcc_pkg::DIR_UP;
        for (int i = 0; i < 512; i++)
        begin
            @(negedge core_clk);
            {sel, sub, cend, cin, a, b} = {i[8:0]};
            #1 r = add(sel == fcc_pkg::INIT_ZERO ? 1'b0 :
                (sel == fcc_pkg::INIT_INPUT ? ~cin : cin));
            check("uponly", {t1, b1, r1, s1},
                {r[2], 2'h0, r[1:0]});
        end
        $display("uponly sweep done");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(negedge core_clk);
        sys_rst = 1'b0;
        test_bidir();
        test_uponly();
        final_report();
    end
    // sweeps take about 3.1 us; a hang is cut well after that
    initial
    begin
        #20000;
        fails++;
        final_report();
    end
endmodule

// [verilog/fcc_pkg.sv]
// constants shared by the fast carry slice
// assumes nothing beyond a sv compiler
package fcc_pkg;
    localparam int unsigned SLICE_BITS = 2;
    // carry direction select codes
    localparam logic DIR_UP = 1'b0;
    localparam logic DIR_DOWN = 1'b1;
    // variant codes
    localparam logic VAR_BIDIR = 1'b0;
    localparam logic VAR_UPONLY = 1'b1;
    // carry-in initialisation select on the second generator's fourth input
    localparam logic [1:0] INIT_CHAIN = 2'h0;
    localparam logic [1:0] INIT_ZERO = 2'h1;
    localparam logic [1:0] INIT_INPUT = 2'h2;
    localparam logic INIT_CONST = 1'b0;
endpackage

// [verilog/fcc_slice.sv]
// fast carry slice of one logic tile: two lookup generators as a 2-bit adder
// assumes neighbours wire carry ports by abutment, configuration bits static
// Functional notes
// [RL1] each generator has dedicated carry and borrow logic
// [RL2] carry out feeds the neighbour tile's incoming carry
// [RL3] two 4-input generators form a 2-bit adder, cascadable to any width
// [RL4] tile to tile carry uses dedicated ports, never general routing
// [RL5] bidirectional variant runs up or down, turns right at column ends
// [RL6] upward-only variant carries upward; downward goes over general routing
// [RL7] upward-only variant exits top only, has no downward carry input; here it keeps the downward_carry_input port and ignores it
// [RL8] carry shares operands and feeds back into generators to form sums
// [RL9] upward-only fourth-input selector offers a programmed zero for carry-in
// [RL10] upward-only variant drops the pass-through selector stage
// [RL11] sum is xor of operands and carry; carry is majority or borrow
`timescale 1ns/10ps
module fcc_slice #(
    parameter logic VARIANT = fcc_pkg::VAR_BIDIR
) (
    // clock and reset, only for assertion sampling
    input wire logic core_clk,
    input wire logic sys_rst,
    // configuration
    input wire logic cfg_dir,
    input wire logic cfg_sub,
    input wire logic cfg_col_end,
    input wire logic [1:0] cfg_init_sel,
    // operands
    input wire logic [fcc_pkg::SLICE_BITS-1:0] op_a,
    input wire logic [fcc_pkg::SLICE_BITS-1:0] op_b,
    input wire logic lut_b_input_four,
    // dedicated carry ports
    input wire logic bottom_carry_input,
    input wire logic downward_carry_input,
    output logic top_carry_exit,
    output logic bottom_carry_exit,
    output logic right_carry_exit,
    // results
    output logic [fcc_pkg::SLICE_BITS-1:0] sum
);
    logic cin;
    logic c_mid;
    logic c_out;
    logic [fcc_pkg::SLICE_BITS-1:0] b_eff;

    // the slice is pure logic; clock and reset only give the checks a
    // sampling point, so they always look at values settled mid-cycle
    default clocking fcc_chk_cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    // operand inversion turns carry into borrow [RL1]
    always_comb
    begin
        // with carry-in held high this gives a minus b with no extra adder
        b_eff = cfg_sub ? ~op_b : op_b;
    end

    // carry-in source; upward-only ignores the downward port and has no pass mux
    always_comb
    begin
        cin = 1'b0;
        if (VARIANT == fcc_pkg::VAR_UPONLY)
        begin
            cin = bottom_carry_input; // [RL7] [RL10]
            case (cfg_init_sel)
                fcc_pkg::INIT_CHAIN: cin = bottom_carry_input;
                fcc_pkg::INIT_ZERO: cin = fcc_pkg::INIT_CONST; // [RL9]
                fcc_pkg::INIT_INPUT: cin = lut_b_input_four; // [RL9]
                default: cin = bottom_carry_input;
            endcase
        end
        else
        begin
            // direction selects which dedicated neighbour feeds us [RL5] [RL4]
            cin = (cfg_dir == fcc_pkg::DIR_UP) ? bottom_carry_input
                                               : downward_carry_input;
        end
    end

    // ripple through both generators with hidden internal carry [RL3] [RL8]
    always_comb
    begin
        sum[0] = op_a[0] ^ b_eff[0] ^ cin; // [RL11]
        c_mid = (op_a[0] & b_eff[0]) | (op_a[0] & cin) | (b_eff[0] & cin);
        sum[1] = op_a[1] ^ b_eff[1] ^ c_mid; // [RL11]
        c_out = (op_a[1] & b_eff[1]) | (op_a[1] & c_mid) | (b_eff[1] & c_mid);
    end

    // steer the carry to the neighbour; at bidirectional column ends it turns right [RL2]
    always_comb
    begin
        top_carry_exit = 1'b0;
        bottom_carry_exit = 1'b0;
        right_carry_exit = 1'b0;
        if (VARIANT == fcc_pkg::VAR_UPONLY)
        begin
            // downward carries must use general routing outside [RL6] [RL7]
            top_carry_exit = c_out;
        end
        else if (cfg_col_end)
            right_carry_exit = c_out; // [RL5]
        else if (cfg_dir == fcc_pkg::DIR_UP)
            top_carry_exit = c_out;
        else
            bottom_carry_exit = c_out;
    end

    // configuration cases shared by the checks, one case per sequence
    sequence s_adding;
        !cfg_sub;
    endsequence

    sequence s_subtracting;
        cfg_sub;
    endsequence

    // carry-in forced high while subtracting means a plain a minus b
    sequence s_plain_sub;
        cfg_sub && cin;
    endsequence

    sequence s_up_variant;
        VARIANT == fcc_pkg::VAR_UPONLY;
    endsequence

    // codes other than zero and input fall back to the chain carry
    sequence s_up_chain;
        VARIANT == fcc_pkg::VAR_UPONLY
            && cfg_init_sel != fcc_pkg::INIT_ZERO
            && cfg_init_sel != fcc_pkg::INIT_INPUT;
    endsequence

    sequence s_up_init_zero;
        VARIANT == fcc_pkg::VAR_UPONLY
            && cfg_init_sel == fcc_pkg::INIT_ZERO;
    endsequence

    sequence s_up_init_input;
        VARIANT == fcc_pkg::VAR_UPONLY
            && cfg_init_sel == fcc_pkg::INIT_INPUT;
    endsequence

    sequence s_bidir_end;
        VARIANT == fcc_pkg::VAR_BIDIR && cfg_col_end;
    endsequence

    sequence s_bidir_down;
        VARIANT == fcc_pkg::VAR_BIDIR && !cfg_col_end
            && cfg_dir == fcc_pkg::DIR_DOWN;
    endsequence

    sequence s_bidir_up;
        VARIANT == fcc_pkg::VAR_BIDIR && !cfg_col_end
            && cfg_dir == fcc_pkg::DIR_UP;
    endsequence

    // add mode: the pair behaves as a plain two-bit adder with carry out
    property p_sum_add;
        s_adding |->
            ({c_out, sum} == {1'b0, op_a} + {1'b0, op_b} + {2'h0, cin});
    endproperty
    AST_SUM_ADD: assert property (p_sum_add) // [RL11]
        else $error("add result wrong");

    // subtract mode adds the inverted operand; carry out is not-borrow
    property p_sum_sub;
        s_subtracting |->
            ({c_out, sum} == {1'b0, op_a} + {1'b0, ~op_b} + {2'h0, cin});
    endproperty
    AST_SUM_SUB: assert property (p_sum_sub) // [RL1]
        else $error("borrow result wrong");

    // with carry-in high the carry drops exactly when a is below b
    property p_borrow;
        s_plain_sub |-> (c_out == (op_a >= op_b));
    endproperty
    AST_BORROW_OUT: assert property (p_borrow) // [RL1]
        else $error("borrow flag wrong");

    // the hidden carry between the generators is bit 0's own carry
    property p_mid_carry;
        {c_mid, sum[0]} == {1'b0, op_a[0]} + {1'b0, b_eff[0]} + {1'b0, cin};
    endproperty
    AST_MID_CARRY: assert property (p_mid_carry) // [RL3]
        else $error("hidden carry wrong");

    // a carry never leaves by two exits at once
    property p_one_exit;
        $onehot0({top_carry_exit, bottom_carry_exit, right_carry_exit});
    endproperty
    AST_ONE_EXIT: assert property (p_one_exit) // [RL2]
        else $error("carry leaves by two exits");

    // and a carry is never lost on its way to the neighbour
    property p_exit_carries;
        (top_carry_exit | bottom_carry_exit | right_carry_exit) == c_out;
    endproperty
    AST_EXIT_CARRIES: assert property (p_exit_carries) // [RL2]
        else $error("carry lost at exit");

    // upward-only: the carry leaves at the top and nowhere else
    property p_up_only;
        s_up_variant |-> (!bottom_carry_exit && !right_carry_exit
            && top_carry_exit == c_out);
    endproperty
    AST_UP_ONLY: assert property (p_up_only) // [RL7]
        else $error("upward-only exit wrong");

    // upward-only chain mode ignores the down port and the direction
    property p_up_chain;
        s_up_chain |-> (cin == bottom_carry_input);
    endproperty
    AST_UP_CHAIN: assert property (p_up_chain) // [RL10]
        else $error("upward chain carry-in wrong");

    // programmed zero on the fourth input starts the chain clear
    property p_init_zero;
        s_up_init_zero |-> !cin;
    endproperty
    AST_INIT_ZERO: assert property (p_init_zero) // [RL9]
        else $error("init zero not zero");

    // the fourth input itself may seed the carry
    property p_init_input;
        s_up_init_input |-> (cin == lut_b_input_four);
    endproperty
    AST_INIT_IN: assert property (p_init_input) // [RL9]
        else $error("init input not routed");

    // bidirectional column end: the carry turns right
    property p_turn_right;
        s_bidir_end |-> (right_carry_exit == c_out
            && !top_carry_exit && !bottom_carry_exit);
    endproperty
    AST_TURN_RIGHT: assert property (p_turn_right) // [RL5]
        else $error("column end carry not right");

    // bidirectional downward chain: in from above, out at the bottom
    property p_dir_down;
        s_bidir_down |-> (bottom_carry_exit == c_out
            && cin == downward_carry_input);
    endproperty
    AST_DIR_DOWN: assert property (p_dir_down) // [RL2]
        else $error("downward chain wrong");

    // bidirectional upward chain: in from below, out at the top
    property p_dir_up;
        s_bidir_up |-> (top_carry_exit == c_out
            && cin == bottom_carry_input);
    endproperty
    AST_DIR_UP: assert property (p_dir_up) // [RL4]
        else $error("upward chain wrong");
endmodule
